// ### core/scp_pkg.sv
// Purpose: Shared constants and types of the serial control port.
// Assumes: APB register map with byte offsets, 32-bit data.
// Notes:   Mailbox bytes are reached by APB and by the external MCU.
package scp_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] SCP_OFS_CTRL = 8'h00; // Control and start.
  localparam logic [7:0] SCP_OFS_STAT = 8'h04; // Busy and done.
  localparam logic [7:0] SCP_OFS_WORD = 8'h08; // Transfer word.
  localparam logic [7:0] SCP_OFS_MBX  = 8'h40; // First mailbox word.

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SCP_CTRL_START = 0;  // Write one to start.
  localparam int SCP_CTRL_LEN3  = 1;  // One selects three bytes.
  localparam int SCP_CTRL_POL   = 2;  // One holds clock high at latch.
  localparam int SCP_CTRL_RATE  = 3;  // Two bits of rate select.
  localparam int SCP_CTRL_TGT   = 5;  // Three bits of codec index.
  localparam int SCP_CTRL_LEAD  = 8;  // Leading-header mode.
  localparam int SCP_CTRL_LDIR  = 9;  // Leading direction bit.
  localparam int SCP_CTRL_LRS   = 10; // Leading select bit.
  localparam int SCP_CTRL_W     = 11; // Stored control width.
  localparam int SCP_STAT_BUSY  = 0;  // Transfer in progress.
  localparam int SCP_STAT_DONE  = 1;  // Sticky, write one clears.

  // ****************************************************
  // Reset values and counts
  // ****************************************************
  localparam logic [10:0] SCP_CTRL_RST = 11'h000; // Control reset.
  localparam logic [23:0] SCP_WORD_RST = 24'h00_0000; // Word reset.
  localparam logic [4:0]  SCP_BITS2    = 5'h10; // Two-byte length.
  localparam logic [4:0]  SCP_BITS3    = 5'h18; // Three-byte length.
  localparam logic [4:0]  SCP_LEADB    = 5'h02; // Header bits.
  localparam logic [4:0]  SCP_SLV_LAST = 5'h17; // Last slave edge.
  localparam logic [4:0]  SCP_SLV_ADR  = 5'h0f; // Address complete.
  // Half shift-clock periods in pclk cycles, indexed by rate.
  localparam logic [3:0][4:0] SCP_HALF = {5'h10, 5'h08, 5'h04, 5'h02};

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    SCP_IDLE  = 2'b00, // Select high, clock idle.
    SCP_SHIFT = 2'b01, // Bits moving.
    SCP_TAIL  = 2'b10  // Hold after last bit.
  } scp_mst_t;

  typedef struct packed {
    logic [5:0] sel_n; // Codec selects, active low.
    logic       sclk;  // Shift clock pin.
    logic       sdo;   // Serial out pin.
    logic       dcf;   // Data or command flag pin.
  } scp_cpin_t;

  typedef struct packed {
    logic        pready;  // Access answered.
    logic        pslverr; // Unmapped address.
    logic [31:0] prdata;  // Read data.
  } scp_apb_rsp_t;

endpackage : scp_pkg

// ### core/scp_top.sv
// Purpose: Serial control port, codec master and MCU slave, APB slave.
// Assumes: pclk 10 MHz; slv_clk is the MCU shift clock, mode 0.
// Notes:   Master shift clock is divided from pclk; slave side
//          runs on slv_clk and hands writes over by a toggle.
`timescale 1ns/1ps

// Function
// - Four-wire master also serves three-wire codecs
// - Codec select frames each master transaction whose codec index is below six
// - Control picks two or three byte words
// - Control picks clock level while codec latches
// - Transfer word shifted out unchanged
// - Read flag position left to software
// - Read leaves captured bits in transfer word
// - Two bits select shift clock rate
// - Up to six codecs, one per transaction
// - Header sends direction then select bit first
// - Data/command flag valid at every eighth edge
// - Slave accesses are exactly three bytes
// - First byte MSB low reads, high writes
// - Second slave byte is register address
// - Slave read drives register on third byte
// - Slave write stores third byte at address
module scp_top #(
  parameter int MB = 8 // Mailbox bytes reachable by the MCU.
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [5:0]  codec_select_n,
  output logic             codec_shift_clock_pin,
  output logic             codec_serial_out,
  input  wire logic        codec_serial_in,
  output logic             data_command_flag,
  input  wire logic        slv_clk,
  input  wire logic        slv_sel_n,
  input  wire logic        slv_mosi,
  output logic             slv_miso_o,
  output logic             slv_miso_oe
);

  // ****************************************************
  // State types
  // ****************************************************
  // All pclk-domain state.
  typedef struct packed {
    scp_pkg::scp_apb_rsp_t apb;   // Bus answer.
    scp_pkg::scp_cpin_t    pin;   // Codec pins.
    scp_pkg::scp_mst_t     st;    // Master state.
    logic [10:0]           ctrl;  // Control fields.
    logic                  go;    // Start pending.
    logic                  busy;  // Transfer running.
    logic                  done;  // Sticky completion.
    logic [23:0]           word;  // Transfer word.
    logic [25:0]           tx;    // Outgoing bits, MSB at top.
    logic [23:0]           rx;    // Captured bits.
    logic [4:0]            bits;  // Bits left.
    logic [4:0]            hc;    // Half-period counter.
    logic                  ph;    // One in latch half.
    logic [1:0]            sdi_s; // Serial in synchroniser.
    logic [2:0]            tsync; // Write toggle synchroniser.
    logic [MB*8-1:0]       mbx;   // Mailbox bytes.
  } scp_pst_t;

  // All slv_clk-domain state except the frame flag.
  typedef struct packed {
    logic [4:0]      bcnt;  // Edges seen in this frame.
    logic            rw;    // One for write.
    logic [7:0]      addr;  // Register address.
    logic [6:0]      sh;    // Last seven input bits.
    logic [7:0]      osh;   // Output shifter, MSB on pin.
    logic            wtog;  // Toggles per finished write.
    logic [7:0]      waddr; // Held write address.
    logic [7:0]      wdata; // Held write data.
    logic [MB*8-1:0] s1;    // First mailbox sync stage.
    logic [MB*8-1:0] s2;    // Second mailbox sync stage.
  } scp_lst_t;

  scp_pst_t r;   // pclk registers.
  scp_pst_t n;   // Their next value.
  scp_lst_t lr;  // slv_clk registers.
  scp_lst_t ln;  // Their next value.
  logic     frm; // High from first slave edge until deselect.

  // ****************************************************
  // Helpers
  // ****************************************************
  // True when a bus address falls in the mailbox window.
  function automatic logic mbx_ok(input logic [7:0] a);
    logic [7:0] d;
    d = a - scp_pkg::SCP_OFS_MBX;
    return a >= scp_pkg::SCP_OFS_MBX && a[1:0] == 2'b00 && (d >> 2) < 8'(MB);
  endfunction : mbx_ok

  // Mailbox slot of a bus address.
  function automatic logic [7:0] mbx_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - scp_pkg::SCP_OFS_MBX;
    return d >> 2;
  endfunction : mbx_idx

  // Byte of a mailbox image; slots past the end read zero.
  function automatic logic [7:0] mbx_rd(input logic [MB*8-1:0] m,
                                        input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i < 8'(MB))
    begin
      v = m[i*8 +: 8];
    end
    return v;
  endfunction : mbx_rd

  // Decoded strobes of the current APB cycle.
  logic acc;    // Access phase before the answer.
  logic wr_eff; // Edge at which a write lands.
  logic [4:0] half;  // Selected half period.
  logic       pol;   // Latch level of the shift clock.
  logic       tedge; // A slave write arrived.

  assign acc    = psel & penable & ~r.apb.pready;
  assign wr_eff = psel & penable & pwrite & r.apb.pready;
  assign half   = scp_pkg::SCP_HALF[r.ctrl[scp_pkg::SCP_CTRL_RATE +: 2]];
  assign pol    = r.ctrl[scp_pkg::SCP_CTRL_POL];
  assign tedge  = r.tsync[2] ^ r.tsync[1];

  // ****************************************************
  // pclk next state: bus, master engine, write handover
  // ****************************************************
  // Writes take effect only at the edge that samples pready high.
  always_comb
  begin
    n = r;
    n.apb.pready  = acc;
    n.apb.pslverr = 1'b0;
    n.apb.prdata  = 32'h0000_0000;
    n.sdi_s = {n.sdi_s[0], codec_serial_in};
    n.tsync = {r.tsync[1:0], lr.wtog};
    // Read data and error are registered at the same edge as pready.
    if (acc)
    begin
      unique case (paddr)
        scp_pkg::SCP_OFS_CTRL: n.apb.prdata = {21'h0, r.ctrl};
        scp_pkg::SCP_OFS_STAT: n.apb.prdata = {30'h0, r.done, r.busy};
        scp_pkg::SCP_OFS_WORD: n.apb.prdata = {8'h00, r.word};
        default:
        begin
          // Mailbox or unmapped.
          if (mbx_ok(paddr))
          begin
            n.apb.prdata = {24'h0, mbx_rd(r.mbx, mbx_idx(paddr))};
          end
          else
          begin
            n.apb.pslverr = 1'b1;
          end
        end
      endcase
    end
    // Register writes; control and word are frozen while busy.
    if (wr_eff)
    begin
      unique case (paddr)
        scp_pkg::SCP_OFS_CTRL:
        begin
          if (!r.busy && !r.go)
          begin
            n.ctrl = pwdata[10:0];
            n.go   = pwdata[scp_pkg::SCP_CTRL_START];
          end
        end
        scp_pkg::SCP_OFS_STAT:
        begin
          // Clear first; a completion below sets it back.
          if (pwdata[scp_pkg::SCP_STAT_DONE])
          begin
            n.done = 1'b0;
          end
        end
        scp_pkg::SCP_OFS_WORD:
        begin
          if (!r.busy && !r.go)
          begin
            n.word = pwdata[23:0];
          end
        end
        default:
        begin
          if (mbx_ok(paddr))
          begin
            n.mbx[mbx_idx(paddr)*8 +: 8] = pwdata[7:0];
          end
        end
      endcase
    end
    // A slave write lands after the bus write, so it wins a tie.
    if (tedge && lr.waddr < 8'(MB))
    begin
      n.mbx[lr.waddr*8 +: 8] = lr.wdata;
    end
    // Shift engine; the word is never interpreted here.
    unique case (r.st)
      scp_pkg::SCP_IDLE:
      begin
        n.pin.sel_n = 6'h3f;
        n.pin.sclk  = ~pol;
        if (r.go)
        begin
          n.go   = 1'b0;
          n.busy = 1'b1;
          n.st   = scp_pkg::SCP_SHIFT;
          n.hc   = half - 5'h01;
          n.ph   = 1'b0;
          // Header bits sit on top and are dropped when unused.
          n.tx = r.ctrl[scp_pkg::SCP_CTRL_LEN3] ?
                 {r.ctrl[scp_pkg::SCP_CTRL_LDIR], r.ctrl[scp_pkg::SCP_CTRL_LRS], r.word} :
                 {r.ctrl[scp_pkg::SCP_CTRL_LDIR], r.ctrl[scp_pkg::SCP_CTRL_LRS],
                  r.word[15:0], 8'h00};
          n.bits = r.ctrl[scp_pkg::SCP_CTRL_LEN3] ? scp_pkg::SCP_BITS3 : scp_pkg::SCP_BITS2;
          if (r.ctrl[scp_pkg::SCP_CTRL_LEAD])
          begin
            n.bits = n.bits + scp_pkg::SCP_LEADB;
          end
          else
          begin
            n.tx = {n.tx[23:0], 2'b00};
          end
          n.pin.sdo = n.tx[25];
          n.pin.dcf = r.ctrl[scp_pkg::SCP_CTRL_LRS];
          // Indices past five select no codec.
          if (r.ctrl[scp_pkg::SCP_CTRL_TGT +: 3] < 3'h6)
          begin
            n.pin.sel_n = ~(6'h01 << r.ctrl[scp_pkg::SCP_CTRL_TGT +: 3]);
          end
        end
      end
      scp_pkg::SCP_SHIFT:
      begin
        if (r.hc != 5'h00)
        begin
          n.hc = r.hc - 5'h01;
        end
        else
        begin
          n.hc = half - 5'h01;
          if (!r.ph)
          begin
            // Enter the latch half at the chosen level.
            n.ph       = 1'b1;
            n.pin.sclk = pol;
          end
          else
          begin
            // Leave latch half: sample input, present next bit.
            // Stale by two cycles, still inside the latch half.
            n.ph       = 1'b0;
            n.pin.sclk = ~pol;
            n.rx       = {r.rx[22:0], r.sdi_s[1]};
            n.tx       = {r.tx[24:0], 1'b0};
            n.pin.sdo  = r.tx[24];
            n.bits     = r.bits - 5'h01;
            if (r.bits == 5'h01)
            begin
              n.st = scp_pkg::SCP_TAIL;
            end
          end
        end
      end
      scp_pkg::SCP_TAIL:
      begin
        // One half period of hold before the select rises.
        if (r.hc != 5'h00)
        begin
          n.hc = r.hc - 5'h01;
        end
        else
        begin
          n.st        = scp_pkg::SCP_IDLE;
          n.pin.sel_n = 6'h3f;
          n.busy      = 1'b0;
          n.done      = 1'b1;
          // Captured bits replace the word; after a write they are junk.
          n.word = r.ctrl[scp_pkg::SCP_CTRL_LEN3] ? r.rx : {8'h00, r.rx[15:0]};
        end
      end
      default:
      begin
        n.st = scp_pkg::SCP_IDLE;
      end
    endcase
  end

  // ****************************************************
  // pclk registers
  // ****************************************************
  // The clock enable freezes every pclk flop, bus answer included.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r          <= '0;
      r.st       <= scp_pkg::SCP_IDLE;
      r.ctrl     <= scp_pkg::SCP_CTRL_RST;
      r.word     <= scp_pkg::SCP_WORD_RST;
      r.pin.sel_n <= 6'h3f;
      r.pin.sclk <= 1'b1;
    end
    else if (pce)
    begin
      r <= n;
    end
  end

  // ****************************************************
  // Slave frame flag
  // ****************************************************
  // The deselect clears it without a clock, since slv_clk stops.
  always_ff @(posedge slv_clk or negedge presetn or posedge slv_sel_n)
  begin
    if (!presetn)
    begin
      frm <= 1'b0;
    end
    else if (slv_sel_n)
    begin
      frm <= 1'b0;
    end
    else
    begin
      frm <= 1'b1;
    end
  end

  // ****************************************************
  // slv_clk next state
  // ****************************************************
  // Mode 0: MCU samples on rising edges, we update after them.
  always_comb
  begin
    logic [4:0] e; // Edge index in this frame.
    e  = frm ? lr.bcnt : 5'h00;
    ln = lr;
    ln.s1 = r.mbx;
    ln.s2 = lr.s1;
    ln.sh = {lr.sh[5:0], slv_mosi};
    ln.bcnt = (e == scp_pkg::SCP_SLV_LAST) ? 5'h00 : e + 5'h01;
    if (e == 5'h00)
    begin
      ln.rw = slv_mosi;
    end
    if (e == scp_pkg::SCP_SLV_ADR)
    begin
      ln.addr = {lr.sh, slv_mosi};
      ln.osh  = mbx_rd(lr.s2, {lr.sh, slv_mosi});
    end
    else if (e > scp_pkg::SCP_SLV_ADR)
    begin
      ln.osh = {lr.osh[6:0], 1'b0};
    end
    if (e == scp_pkg::SCP_SLV_LAST && lr.rw)
    begin
      ln.waddr = lr.addr;
      ln.wdata = {lr.sh, slv_mosi};
      ln.wtog  = ~lr.wtog;
    end
  end

  // ****************************************************
  // slv_clk registers
  // ****************************************************
  // Held address and data stay put until the next write ends.
  always_ff @(posedge slv_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      lr <= '0;
    end
    else
    begin
      lr <= ln;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign prdata                = r.apb.prdata;
  assign pready                = r.apb.pready;
  assign pslverr               = r.apb.pslverr;
  assign codec_select_n        = r.pin.sel_n;
  assign codec_shift_clock_pin = r.pin.sclk;
  assign codec_serial_out      = r.pin.sdo;
  assign data_command_flag     = r.pin.dcf;
  assign slv_miso_o            = lr.osh[7];
  assign slv_miso_oe           = frm;

  // ****************************************************
  // Assertions
  // ****************************************************
  // Idle master keeps every select high.
  property p_sel_idle;
    @(posedge pclk) disable iff (!presetn)
      (r.st == scp_pkg::SCP_IDLE && !r.busy) |-> codec_select_n == 6'h3f;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select low while idle");

  // During shifting at most one select is low.
  property p_sel_one;
    @(posedge pclk) disable iff (!presetn)
      r.st == scp_pkg::SCP_SHIFT |-> $countones(~codec_select_n) <= 1;
  endproperty
  a_sel_one: assert property (p_sel_one) else $error("more than one codec selected");

  // Starting loads the length chosen by control.
  property p_len;
    @(posedge pclk) disable iff (!presetn)
      (pce && r.st == scp_pkg::SCP_IDLE && r.go && !r.ctrl[scp_pkg::SCP_CTRL_LEAD])
      |=> r.bits == ($past(r.ctrl[scp_pkg::SCP_CTRL_LEN3]) ? 5'h18 : 5'h10);
  endproperty
  a_len: assert property (p_len) else $error("wrong transfer length");

  // Clock sits at the latch level during the latch half.
  property p_latch;
    @(posedge pclk) disable iff (!presetn)
      (r.st == scp_pkg::SCP_SHIFT && r.ph) |-> codec_shift_clock_pin == pol;
  endproperty
  a_latch: assert property (p_latch) else $error("latch level wrong");

  // Clock never toggles on two edges in a row.
  property p_rate;
    @(posedge pclk) disable iff (!presetn)
      (pce && $changed(codec_shift_clock_pin) && r.st == scp_pkg::SCP_SHIFT)
      |=> $stable(codec_shift_clock_pin);
  endproperty
  a_rate: assert property (p_rate) else $error("shift clock too fast");

  // Header mode opens with the direction bit.
  sequence s_lead_go;
    pce && r.st == scp_pkg::SCP_IDLE && r.go && r.ctrl[scp_pkg::SCP_CTRL_LEAD];
  endsequence
  property p_lead;
    @(posedge pclk) disable iff (!presetn)
      s_lead_go |=> codec_serial_out == $past(r.ctrl[scp_pkg::SCP_CTRL_LDIR]);
  endproperty
  a_lead: assert property (p_lead) else $error("header bit missing");

  // The flag stays still for the whole frame.
  property p_dcf;
    @(posedge pclk) disable iff (!presetn)
      (r.st == scp_pkg::SCP_SHIFT && $past(r.st) == scp_pkg::SCP_SHIFT)
      |-> $stable(data_command_flag);
  endproperty
  a_dcf: assert property (p_dcf) else $error("flag moved mid frame");

  // A handed-over slave write reaches the mailbox next edge.
  property p_handover;
    @(posedge pclk) disable iff (!presetn)
      (pce && tedge && lr.waddr < 8'(MB))
      |=> r.mbx[$past(lr.waddr)*8 +: 8] == $past(lr.wdata);
  endproperty
  a_handover: assert property (p_handover) else $error("slave write lost");

  // Frame edge counter wraps after the third byte.
  property p_three;
    @(posedge slv_clk) disable iff (!presetn)
      (frm && lr.bcnt == 5'h17) |=> lr.bcnt == 5'h00;
  endproperty
  a_three: assert property (p_three) else $error("slave frame not three bytes");

endmodule : scp_top

// ### test/scp_codec_model.sv
// Purpose: Behavioural codec on the far side of the master link.
// Assumes: One frame at a time; selects are active low.
// Notes:   Answers in setup halves; a released input shows its inverse.
`timescale 1ns/1ps
module scp_codec_model (
  input  wire logic [5:0]  sel_n,
  input  wire logic        sclk,
  input  wire logic        sdo,
  input  wire logic        pol,
  input  wire logic [25:0] reply,
  input  wire logic [4:0]  total,
  output logic             sdi,
  output logic [25:0]      got,
  output logic [7:0]       byt,
  output logic [5:0]       fsel,
  output int               nlat,
  output int               per
);
  wire     frm = ~&sel_n; // High while some codec is selected.
  realtime tl;            // Time of the previous latch edge.

  initial sdi = 1'b0;

  // A new frame clears the capture and shows the first reply bit.
  always @(posedge frm)
  begin
    got = '0;
    nlat = 0;
    sdi = reply[total - 1];
  end

  // The released line must not keep its last value.
  always @(negedge frm) sdi = ~sdi;

  // Capture in the latch level, answer in the setup level.
  always @(sclk)
  begin
    if (frm && sclk === pol)
    begin
      got = {got[24:0], sdo};
      fsel = sel_n;
      per = int'($realtime - tl);
      tl = $realtime;
      nlat++;
      // Every eighth latch edge completes one parallel byte.
      if (nlat % 8 == 0)
        byt = got[7:0];
    end
    else if (frm)
      sdi = (nlat < total) ? reply[total - 1 - nlat] : 1'b0;
  end
endmodule : scp_codec_model

// ### test/serial_control_port_tb.sv
// Purpose: Self-checking bench of the serial control port.
// Assumes: Codec model on the master link; bench plays the slave MCU.
// Notes:   Random words and settings under a fixed seed.
`timescale 1ns/1ps
module serial_control_port_tb;
  logic        pclk, presetn, psel, penable, pwrite, sdi, slv_clk, slv_sel_n, slv_mosi;
  logic        pce, miso, moe; // Clock enable, slave data out and its enable.
  logic [7:0]  paddr, rx, b, byt;
  logic [31:0] pwdata, prdata, rd, wd;
  logic        pready, pslverr, er, sclk, sdo, dcf, pol, len3, lead, ldir, lrs;
  logic [5:0]  sel_n, fsel;
  logic [25:0] reply, got;
  logic [4:0]  total;
  int          nlat, per, n_errors, checked, i, k, tgt, a;

  always #50 pclk = ~pclk;

  scp_top #(.MB(8)) i_scp_top (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .codec_select_n(sel_n),
    .codec_shift_clock_pin(sclk), .codec_serial_out(sdo), .codec_serial_in(sdi),
    .data_command_flag(dcf), .slv_clk(slv_clk), .slv_sel_n(slv_sel_n),
    .slv_mosi(slv_mosi), .slv_miso_o(miso), .slv_miso_oe(moe));
  scp_codec_model i_scp_codec_model (.sel_n(sel_n), .sclk(sclk), .sdo(sdo), .pol(pol),
    .reply(reply), .total(total), .sdi(sdi), .got(got), .byt(byt), .fsel(fsel),
    .nlat(nlat), .per(per));

  // Counts every comparison and reports a mismatch at once.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    $display("Mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One 24-bit MCU frame, mode 0; the clock runs only inside it.
  task slv(input logic [23:0] tx, output logic [7:0] q);
    @(posedge pclk) slv_sel_n <= 1'b0;
    #7;
    for (int j = 0; j < 24; j++)
    begin
      slv_mosi = tx[23 - j];
      #3 if (j >= 16) q = {q[6:0], miso};
      if (j == 16) chk(moe, 1'b1);
      slv_clk = 1'b1;
      #3 slv_clk = 1'b0;
    end
    #3 slv_sel_n = 1'b1;
    #1 chk(moe, 1'b0);
  endtask : slv

  // Bits that must leave the port, right-aligned, header first.
  function logic [25:0] exp_bits(logic [23:0] w, logic l3, logic ld, logic dr, logic rs);
    logic [25:0] v;
    v = l3 ? {2'b00, w} : {10'h000, w[15:0]};
    if (ld)
      v = v | ({24'h00_0000, dr, rs} << (l3 ? 24 : 16));
    return v;
  endfunction : exp_bits

  // A hang anywhere ends the run as a failure.
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, slv_clk, slv_mosi, pol} = '0;
    {paddr, pwdata, reply, n_errors, checked} = '0;
    slv_sel_n = 1'b1;
    pce = 1'b1;
    total = 5'h10;
    void'($urandom(32'h44a8b912));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(sel_n, 6'h3f);
    for (i = 0; i < 8; i++)
    begin
      {len3, lead, ldir, lrs} = 4'($urandom);
      pol = i[2];
      tgt = $urandom % 6;
      reply = 26'($urandom);
      total = (len3 ? 5'h18 : 5'h10) + (lead ? 5'h02 : 5'h00);
      wd = $urandom;
      apb(1'b1, scp_pkg::SCP_OFS_WORD, wd);
      apb(1'b1, scp_pkg::SCP_OFS_STAT, 32'h0000_0002);
      apb(1'b1, scp_pkg::SCP_OFS_CTRL, {21'h0, lrs, ldir, lead, 3'(tgt), 2'(i), pol, len3, 1'b1});
      if (i == 0)
      begin
        // Freeze the frame just started; select, shift clock and serial out must hold still.
        @(posedge pclk) pce <= 1'b0;
        repeat (2) @(posedge pclk);
        rd = 32'({sel_n, sclk, sdo});
        repeat (20) @(posedge pclk);
        chk(32'({sel_n, sclk, sdo}), rd);
        pce <= 1'b1;
      end
      k = 0;
      do
      begin
        apb(1'b0, scp_pkg::SCP_OFS_STAT, 32'h0);
        k++;
      end while (rd[1] !== 1'b1 && k < 400);
      chk(32'(k < 400), 32'h1);
      chk(got, exp_bits(wd[23:0], len3, lead, ldir, lrs));
      chk(byt, 8'(exp_bits(wd[23:0], len3, lead, ldir, lrs) >> (lead ? 2 : 0)));
      chk(nlat, total);
      chk(per, 200 * (2 << (i % 4)));
      chk(fsel, 6'(~(6'h01 << tgt)));
      chk(dcf, lrs);
      chk(sclk, 1'(~pol));
      chk(sel_n, 6'h3f);
      if (!lead)
      begin
        apb(1'b0, scp_pkg::SCP_OFS_WORD, 32'h0);
        chk(rd[23:0], len3 ? reply[23:0] : {8'h00, reply[15:0]});
      end
    end
    for (i = 0; i < 4; i++)
    begin
      a = $urandom % 8;
      b = 8'($urandom);
      slv({8'h80 | 8'($urandom), 8'(a), b}, rx);
      repeat (10) @(posedge pclk);
      apb(1'b0, scp_pkg::SCP_OFS_MBX + 8'(4 * a), 32'h0);
      chk(rd[7:0], b);
      b = 8'($urandom);
      apb(1'b1, scp_pkg::SCP_OFS_MBX + 8'(4 * a), {24'h0, b});
      repeat (4) @(posedge pclk);
      slv({8'h7f & 8'($urandom), 8'(a), 8'($urandom)}, rx);
      chk(rx, b);
    end
    // An unmapped offset must be refused with an error.
    apb(1'b0, 8'h3c, 32'h0);
    chk(er, 1'b1);
    conclude();
  end
endmodule : serial_control_port_tb
